// ===== rtl/hmp_map.svh
/*
 holds the timing and layout constants of the host microcontroller port.
 assumes inclusion by the port's package and modules only.
*/
`ifndef HMP_MAP_SVH
`define HMP_MAP_SVH
`define HMP_CORE_CLK_HZ 50000000
`define HMP_ADDR_W 8
`define HMP_DATA_W 8
`define HMP_REGS 256
`define HMP_SER_CMD_BITS 8
`define HMP_SER_RD_BIT 0
`define HMP_ACK_HOLD_CYC 2
`define HMP_RDY_BUSY_CYC 2
`endif

// ===== rtl/hmp_pkg.sv
/*
 holds the types of the host microcontroller port.
 assumes hmp_map.svh is on the include path.
*/
`include "hmp_map.svh"
package hmp_pkg;
	typedef enum logic [1:0] {
		HMP_MODE_SERIAL,
		HMP_MODE_INTEL,
		HMP_MODE_MOTO
	} hmp_mode_e;
	typedef enum logic [1:0] {
		HMP_SER_CMD,
		HMP_SER_ADDR,
		HMP_SER_DATA
	} hmp_ser_e;
	typedef logic [`HMP_DATA_W-1:0] hmp_byte_t;
endpackage

// ===== rtl/hmp_regmem.sv
/*
 holds a small register memory, one write port and a registered read port.
 assumes a single core clock; contents are not reset.
*/
`timescale 1ns/1ps
module hmp_regmem #(
	parameter int DEPTH = 256,
	parameter int AW = 8,
	parameter int DW = 8
) (
	input wire logic i_core_clk, // core clock
	input wire logic i_we, // write enable
	input wire logic [AW-1:0] i_waddr, // write address
	input wire logic [DW-1:0] i_wdata, // write data
	input wire logic [AW-1:0] i_raddr, // read address
	output logic [DW-1:0] o_rdata // registered read data
);
	logic [DW-1:0] mem [DEPTH];
	always_ff @(posedge i_core_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule // hmp_regmem

// ===== rtl/hmp_port.sv
/*
 holds the host port: serial shift interface and multiplexed intel or motorola
 parallel bus, all sampled by the core clock, backed by a register memory.
 assumes every host pin is asynchronous to i_core_clk and that the shift clock
 and strobes are far slower than the core clock.
*/
// Contract
// - serial_out shifts on edge chosen by out_edge_select
// - motorola read: ack low means data valid
// - motorola write: ack low means data accepted
// - intel: ready low while busy, high done
// - intel: drive data while read strobe low
// - motorola rw low: capture write on strobe
// - motorola rw high: drive read under strobe
// - eight lines carry address and data
// - serial_in sampled on shift_clock rising edge
// - intel address latched on latch strobe fall
// - motorola address latched on addr_strobe fall
`timescale 1ns/1ps
`include "hmp_map.svh"
module hmp_port #(
	parameter int ACK_HOLD = `HMP_ACK_HOLD_CYC,
	parameter int RDY_BUSY = `HMP_RDY_BUSY_CYC
) (
	input wire logic i_core_clk, // core clock
	input wire logic i_rst_n, // sync reset, active low
	input wire logic [1:0] i_mode, // hmp_mode_e interface select strap
	input wire logic i_chip_select_n, // interface enable, active low
	input wire logic i_shift_clock, // serial shift clock
	input wire logic i_serial_in, // serial data in
	input wire logic i_out_edge_select, // high: shift out on falling edge
	output logic o_serial_out, // serial data out
	input wire logic i_addr_latch_strobe, // intel address latch
	input wire logic i_addr_strobe, // motorola address strobe
	input wire logic i_read_strobe_n, // intel read strobe
	input wire logic i_write_strobe_n, // intel write strobe
	input wire logic i_data_strobe_n, // motorola data strobe
	input wire logic i_read_write_select, // motorola: high read, low write
	input wire logic [7:0] i_ad, // multiplexed bus in
	output logic [7:0] o_ad, // multiplexed bus out
	output logic o_ad_oe_n, // bus drive enable, low drives
	output logic o_bus_acknowledge_n, // motorola acknowledge
	output logic o_cycle_ready // intel ready
);
	//----------------------------------------
	// pin synchronisers
	//----------------------------------------
	localparam int NS = 18;
	logic [NS-1:0] s1_reg, s2_reg, s3_reg;
	wire [NS-1:0] pins = {i_chip_select_n, i_shift_clock, i_serial_in, i_out_edge_select,
		i_addr_latch_strobe, i_addr_strobe, i_read_strobe_n, i_write_strobe_n,
		i_data_strobe_n, i_read_write_select, i_ad};
	always_ff @(posedge i_core_clk) begin
		s1_reg <= pins;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end
	wire cs_act = ~s2_reg[17];
	wire sck = s2_reg[16];
	wire sck_rise = sck & ~s3_reg[16];
	wire sck_fall = ~sck & s3_reg[16];
	wire serial_in = s2_reg[15];
	wire oes = s2_reg[14];
	wire ale_fall = ~s2_reg[13] & s3_reg[13];
	wire as_fall = ~s2_reg[12] & s3_reg[12];
	wire rd_low = ~s2_reg[11];
	wire wr_low = ~s2_reg[10];
	wire wr_rise = s2_reg[10] & ~s3_reg[10];
	wire ds_low = ~s2_reg[9];
	wire ds_rise = s2_reg[9] & ~s3_reg[9];
	wire rnw = s2_reg[8];
	wire [7:0] ad_s = s2_reg[7:0];
	wire is_ser = i_mode == hmp_pkg::HMP_MODE_SERIAL;
	wire is_intel = i_mode == hmp_pkg::HMP_MODE_INTEL;
	wire is_moto = i_mode == hmp_pkg::HMP_MODE_MOTO;
	//----------------------------------------
	// serial engine
	//----------------------------------------
	// frame: 8-bit command (bit0 set = read), 8-bit address, 8 data bits, lsb first
	hmp_pkg::hmp_ser_e ser_reg, ser_next;
	logic [7:0] sh_reg;
	logic [2:0] cnt_reg;
	logic ser_rd_reg;
	logic [7:0] ser_addr_reg;
	logic [7:0] sout_reg;
	logic sdo_reg;
	logic [7:0] rdata;
	wire ser_go = is_ser & cs_act;
	wire [7:0] sh_in = {serial_in, sh_reg[7:1]};
	wire bit_last = cnt_reg == 3'h7;
	wire out_edge = oes ? sck_fall : sck_rise;
	always_comb begin
		ser_next = ser_reg;
		if (sck_rise && bit_last) begin
			case (ser_reg)
				hmp_pkg::HMP_SER_CMD: ser_next = hmp_pkg::HMP_SER_ADDR;
				hmp_pkg::HMP_SER_ADDR: ser_next = hmp_pkg::HMP_SER_DATA;
				hmp_pkg::HMP_SER_DATA: ser_next = hmp_pkg::HMP_SER_CMD;
				default: ser_next = hmp_pkg::HMP_SER_CMD;
			endcase
		end
	end
	wire ser_wr = ser_go & sck_rise & bit_last & ~ser_rd_reg & ser_reg == hmp_pkg::HMP_SER_DATA;
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !ser_go) begin
			ser_reg <= hmp_pkg::HMP_SER_CMD;
			cnt_reg <= 3'h0;
			sh_reg <= 8'h00;
			ser_rd_reg <= 1'b0;
			ser_addr_reg <= 8'h00;
		end else if (sck_rise) begin
			sh_reg <= sh_in;
			cnt_reg <= cnt_reg + 3'h1;
			ser_reg <= ser_next;
			if (bit_last && ser_reg == hmp_pkg::HMP_SER_CMD) begin
				ser_rd_reg <= sh_in[`HMP_SER_RD_BIT];
			end
			if (bit_last && ser_reg == hmp_pkg::HMP_SER_ADDR) begin
				ser_addr_reg <= sh_in;
			end
		end
	end
	// read data loaded once the address is in; shifted out on the chosen edge
	// two stages: address register first, then the registered memory read
	logic [1:0] load_pend_reg;
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !ser_go) begin
			load_pend_reg <= 2'h0;
			sout_reg <= 8'h00;
			sdo_reg <= 1'b0;
		end else begin
			load_pend_reg <= {load_pend_reg[0],
				sck_rise & bit_last & ser_reg == hmp_pkg::HMP_SER_ADDR};
			if (load_pend_reg[1]) begin
				sout_reg <= rdata;
			end else if (out_edge && ser_reg == hmp_pkg::HMP_SER_DATA && ser_rd_reg) begin
				sdo_reg <= sout_reg[0];
				sout_reg <= {1'b0, sout_reg[7:1]};
			end
		end
	end
	//----------------------------------------
	// parallel engine
	//----------------------------------------
	logic [7:0] par_addr_reg;
	logic [7:0] ad_out_reg;
	logic oe_n_reg;
	logic ack_n_reg;
	logic rdy_reg;
	logic [3:0] hold_reg;
	logic rdy_seen_reg;
	logic [3:0] rdy_cnt_reg;
	// intel write completes on write strobe release, motorola on data strobe release
	wire intel_wr = is_intel & cs_act & wr_rise;
	wire moto_wr = is_moto & cs_act & ds_rise & ~rnw;
	wire intel_rd = is_intel & cs_act & rd_low;
	wire moto_rd = is_moto & cs_act & ds_low & rnw;
	wire drive = intel_rd | moto_rd;
	wire par_busy = is_intel & cs_act & (rd_low | wr_low);
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			par_addr_reg <= 8'h00;
		end else if (cs_act && ((is_intel && ale_fall) || (is_moto && as_fall))) begin
			par_addr_reg <= ad_s;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			ad_out_reg <= 8'h00;
			oe_n_reg <= 1'b1;
			ack_n_reg <= 1'b1;
			rdy_reg <= 1'b1;
			hold_reg <= 4'h0;
		end else begin
			oe_n_reg <= ~drive;
			ad_out_reg <= rdata;
			// ack drops one cycle after bus is driven, so data is settled
			if (moto_rd && !oe_n_reg) begin
				ack_n_reg <= 1'b0;
			end else if (moto_wr) begin
				ack_n_reg <= 1'b0;
				hold_reg <= 4'(ACK_HOLD);
			end else if (hold_reg != 4'h0) begin
				hold_reg <= hold_reg - 4'h1;
			end else begin
				ack_n_reg <= 1'b1;
			end
			// ready low for a fixed access time after a strobe goes low
			if (!par_busy) begin
				rdy_reg <= 1'b1;
			end else if (rdy_reg && !rdy_seen_reg) begin
				rdy_reg <= 1'b0;
			end else if (!rdy_reg && rdy_cnt_reg == 4'(RDY_BUSY)) begin
				rdy_reg <= 1'b1;
			end
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !par_busy) begin
			rdy_seen_reg <= 1'b0;
			rdy_cnt_reg <= 4'h0;
		end else begin
			rdy_seen_reg <= 1'b1;
			if (!rdy_reg && rdy_cnt_reg != 4'(RDY_BUSY)) begin
				rdy_cnt_reg <= rdy_cnt_reg + 4'h1;
			end
		end
	end
	//----------------------------------------
	// register memory
	//----------------------------------------
	wire mem_we = ser_wr | intel_wr | moto_wr;
	wire [7:0] mem_wdata = ser_wr ? sh_in : ad_s;
	wire [7:0] mem_addr = is_ser ? ser_addr_reg : par_addr_reg;
	hmp_regmem #(
		.DEPTH(`HMP_REGS),
		.AW(`HMP_ADDR_W),
		.DW(`HMP_DATA_W)
	) u_mem (
		.i_core_clk(i_core_clk),
		.i_we(mem_we),
		.i_waddr(mem_addr),
		.i_wdata(mem_wdata),
		.i_raddr(mem_addr),
		.o_rdata(rdata)
	);
	assign o_serial_out = sdo_reg;
	assign o_ad = ad_out_reg;
	assign o_ad_oe_n = oe_n_reg;
	assign o_bus_acknowledge_n = ack_n_reg;
	assign o_cycle_ready = rdy_reg;
endmodule // hmp_port

// ===== verification/hmp_port_chk.sv
/*
 handshake and bus release checker for hmp_port.
 assumes host pins idle during reset.
*/
`timescale 1ns/1ps
module hmp_port_chk (
	input wire logic i_core_clk, // clock
	input wire logic i_rst_n, // reset
	input wire logic [1:0] i_mode, // strap
	input wire logic i_chip_select_n, // enable
	input wire logic i_read_strobe_n, // read
	input wire logic i_data_strobe_n, // strobe
	input wire logic i_read_write_select, // dir
	input wire logic o_ad_oe_n, // drive
	input wire logic o_bus_acknowledge_n, // ack
	input wire logic o_cycle_ready // ready
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	wire sel_i = i_mode == 2'h1 && !i_chip_select_n;
	wire sel_m = i_mode == 2'h2 && !i_chip_select_n;
	wire m_rd = sel_m && !i_data_strobe_n && i_read_write_select;
	property p_sq; i_mode == 2'h0 |-> o_ad_oe_n; endproperty
	a_sq: assert property (p_sq) else $error("serial bus drive");
	property p_rel; (i_read_strobe_n && i_data_strobe_n)[*5] |-> o_ad_oe_n; endproperty
	a_rel: assert property (p_rel) else $error("bus held");
	property p_idr; (sel_i && !i_read_strobe_n)[*6] |-> !o_ad_oe_n; endproperty
	a_idr: assert property (p_idr) else $error("no read drive");
	property p_mdr; m_rd[*6] |-> !o_ad_oe_n; endproperty
	a_mdr: assert property (p_mdr) else $error("no read drive");
	property p_rak; m_rd[*7] |-> !o_bus_acknowledge_n; endproperty
	a_rak: assert property (p_rak) else $error("no read ack");
	property p_wak; $rose(i_data_strobe_n) && sel_m && !i_read_write_select
		|-> ##[1:5] !o_bus_acknowledge_n; endproperty
	a_wak: assert property (p_wak) else $error("no write ack");
	property p_rdy; $fell(i_read_strobe_n) && sel_i
		|-> ##[1:5] !o_cycle_ready ##[1:6] o_cycle_ready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready order");
	property p_off; i_chip_select_n[*5] |-> o_ad_oe_n && o_bus_acknowledge_n; endproperty
	a_off: assert property (p_off) else $error("active while off");
	c_rdy: cover property (!o_cycle_ready);
	c_rak: cover property (!o_bus_acknowledge_n && i_read_write_select);
	c_wak: cover property (!o_bus_acknowledge_n && !i_read_write_select);
endmodule // hmp_port_chk
bind hmp_port hmp_port_chk u_hmp_port_chk (.*);

// ===== verification/hmp_host_model.sv
/*
 serial side of the host: frames of 24 bits on a 160 ns shift clock.
 assumes the bench calls frame and merges chip select.
*/
`timescale 1ns/1ps
module hmp_host_model (
	input wire logic i_out_edge_select, // active out edge
	input wire logic i_serial_out, // device data
	output logic o_shift_clock, // still outside frames
	output logic o_serial_in, // host data
	output logic o_chip_select_n // frame enable
);
	initial begin
		o_shift_clock = 0;
		o_serial_in = 1;
		o_chip_select_n = 1;
	end
	task automatic frame(input logic [23:0] f, output logic [7:0] rd);
		#7 o_chip_select_n = 0;
		for (int i = 0; i < 24; i++) begin
			o_serial_in = f[i];
			#80 o_shift_clock = 1;
			if (i > 15 && i_out_edge_select) rd[i-16] = i_serial_out;
			#80 o_shift_clock = 0;
			if (i > 15 && !i_out_edge_select) rd[i-16] = i_serial_out;
		end
		// released line flips so a stale value cannot pass
		#80 o_serial_in = ~o_serial_in;
		o_chip_select_n = 1;
	endtask
endmodule // hmp_host_model

// ===== verification/tb_host_microcontroller_port.sv
/*
 bench for hmp_port: intel, motorola and serial accesses with queued checks.
 assumes hmp_host_model on the serial side and a pulled-down bus.
*/
`timescale 1ns/1ps
module tb_host_microcontroller_port;
	logic i_core_clk = 0, i_rst_n = 0, cs_n = 1, ale = 0, rd_n = 1, wr_n = 1, ds_n = 1;
	logic rw = 0, oes = 0, hen = 0;
	logic [1:0] mode = 2'h1;
	logic [7:0] hdrv = 8'h00, seen, d[6];
	logic [7:0] q[$];
	int n_fail = 0, checked = 0, cyc = 0;
	wire sclk, serial_in, scs_n, serial_out, oe_n, ack_n, rdy;
	wire [7:0] ad_out;
	wire [7:0] ad = !oe_n ? ad_out : hen ? hdrv : 8'h00;
	event take;
	always #10 i_core_clk = ~i_core_clk;
	hmp_port u_hmp_port (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_mode(mode),
		.i_chip_select_n(cs_n & scs_n), .i_shift_clock(sclk), .i_serial_in(serial_in),
		.i_out_edge_select(oes), .o_serial_out(serial_out), .i_addr_latch_strobe(ale),
		.i_addr_strobe(ale), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
		.i_data_strobe_n(ds_n), .i_read_write_select(rw), .i_ad(ad), .o_ad(ad_out),
		.o_ad_oe_n(oe_n), .o_bus_acknowledge_n(ack_n), .o_cycle_ready(rdy));
	hmp_host_model u_hmp_host_model (.i_out_edge_select(oes), .i_serial_out(serial_out),
		.o_shift_clock(sclk), .o_serial_in(serial_in), .o_chip_select_n(scs_n));
	task automatic chk(input logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	always @(take) chk(seen, q.pop_front());
	task automatic summarize();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic tick(int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	task automatic go(input logic [1:0] m);
		i_rst_n = 0;
		mode = m;
		tick(3);
		i_rst_n = 1;
		tick(4);
	endtask
	// address phase, then one strobe held 10 cycles; reads note their expectation
	task automatic pacc(input logic wr, c, input logic [7:0] a, v);
		cs_n = c;
		rw = !wr;
		hdrv = a;
		hen = 1;
		ale = 1;
		tick(4);
		ale = 0;
		tick(4);
		hdrv = v;
		hen = wr;
		if (mode == 2'h1 && wr) wr_n = 0;
		else if (mode == 2'h1) rd_n = 0;
		else ds_n = 0;
		tick(10);
		if (!wr) q.push_back(v);
		seen = ad;
		if (!wr) -> take;
		{rd_n, wr_n, ds_n} = 3'h7;
		tick(8);
		hen = 0;
		cs_n = 1;
		tick(2);
	endtask
	task automatic sacc(input logic wr, input logic [7:0] a, v);
		logic [7:0] r;
		u_hmp_host_model.frame({v, a, 7'h00, !wr}, r);
		tick(4);
		if (!wr) q.push_back(v);
		seen = r;
		if (!wr) -> take;
	endtask
	initial begin
		void'($urandom(32'hb2fd937a));
		foreach (d[k]) d[k] = 8'($urandom());
		for (int m = 1; m < 3; m++) begin
			go(m[1:0]);
			pacc(1, 0, 8'h00, d[2*m-2]);
			pacc(1, 0, 8'hff, d[2*m-1]);
			pacc(1, 1, 8'h00, ~d[2*m-2]);
			pacc(0, 0, 8'hff, d[2*m-1]);
			pacc(0, 0, 8'h00, d[2*m-2]);
			$display("test parallel mode %0d done", m);
		end
		go(2'h0);
		for (int e = 0; e < 2; e++) begin
			oes = e[0];
			tick(1);
			sacc(1, 8'h5a, d[4+e]);
			sacc(0, 8'h5a, d[4+e]);
			sacc(0, 8'hff, d[3]);
			$display("test serial edge %0d done", e);
		end
		summarize();
	end
endmodule // tb_host_microcontroller_port
